// *** nvac_cfg.svh ***
// register offsets, bit positions, reset values and timing for the nv access block
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
`define NVAC_OFF_DATA_LO   8'h9a
`define NVAC_OFF_ADDR_LO   8'h9b
`define NVAC_OFF_CTRL      8'h9c
`define NVAC_OFF_UNLOCK    8'h9d
`define NVAC_OFF_DATA_HI   8'h97
`define NVAC_OFF_ADDR_HI   8'h98
`define NVAC_BIT_RD        0
`define NVAC_BIT_WR        1
`define NVAC_BIT_WRITE_ENABLE_GATE      2
`define NVAC_BIT_WRITE_ERROR_FLAG     3
`define NVAC_BIT_MSEL      7
`define NVAC_RST_BYTE      8'h00
`define NVAC_KEY1          8'h55
`define NVAC_KEY2          8'haa
`define NVAC_WRITE_US      4000
`define NVAC_CLK_MHZ       10
`define NVAC_WRITE_CYC     (`NVAC_WRITE_US * `NVAC_CLK_MHZ)
`define NVAC_EE_DEPTH      256
`define NVAC_PM_DEPTH      4096
`endif

// *** nvac_pkg.sv ***
// types for the nv access block
package nvac_pkg;
  typedef enum logic [3:0] {
    NVAC_IDLE   = 4'b0001,
    NVAC_PMWAIT = 4'b0010,
    NVAC_WRITE  = 4'b0100,
    NVAC_RDONE  = 4'b1000
  } nvac_state_e;
  typedef enum logic [2:0] {
    NVAC_LK_NONE = 3'b001,
    NVAC_LK_ONE  = 3'b010,
    NVAC_LK_TWO  = 3'b100
  } nvac_lock_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvac_bus_s;
  typedef struct packed {
    nvac_state_e state;
    nvac_lock_e  lock;
    logic [7:0]  data_lo;
    logic [5:0]  data_hi;
    logic [7:0]  addr_lo;
    logic [3:0]  addr_hi;
    logic        msel;
    logic        write_enable_gate;
    logic        write_error_flag;
    logic        wr_bit;
    logic        rd_bit;
    logic        done_flag;
    logic [31:0] timer;
    logic [7:0]  rdata;
  } nvac_state_s;
endpackage

// *** nvac_top.sv ***
// nv data and program memory access controller
`include "nvac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
// how the block is used
//
// register map, one byte each
//   9a  data low byte
//   9b  address low byte
//   9c  control and status
//   9d  unlock target, no storage
//   97  data high byte, six bits
//   98  address high byte, four bits
//
// control byte layout
//   bit 7  memory select, 1 = program store
//   bit 6  reads zero
//   bit 5  reads zero
//   bit 4  reads zero
//   bit 3  write error flag
//   bit 2  write gate
//   bit 1  write strobe, set only
//   bit 0  read strobe, set only
//
// read data timing
//   read data is registered
//   it shows the addressed register
//   one clock after the address
//   the read qualifier is not needed
//   reads have no side effects
//
// data store read
//   load address low byte
//   write control with select clear, bit 0 set
//   read strobe clears one clock later
//   data low byte loaded at that edge
//
// program store read
//   load address high, then low
//   write control with select set, bit 0 set
//   one extra clock of wait
//   both data bytes loaded on the next edge
//   read strobe clears with the load
//
// data store write
//   load address and data low byte
//   set the write gate
//   write 55h, then aah, to the unlock target
//   then write control with bit 1 set
//   any other register write breaks the key
//   the control write itself spends the key
//
// while a write runs
//   the write strobe reads back high
//   the busy output follows the strobe
//   only the write gate bit can change
//   data and address are frozen
//   unlock writes are ignored
//   new read strobes are ignored
//
// end of a write
//   the timer counts down every clock
//   the byte lands on the last count
//   old contents are replaced whole
//   strobe clears, completion flag sets
//   the key is spent again
//
// completion flag
//   sticky until the clear pulse
//   a set in the same clock wins
//   the clear pulse has no other effect
//
// reset behaviour
//   reset is synchronous and active high
//   every reset clears strobes and gate
//   every reset returns select to data
//   reset during a write sets the error flag
//   the cut write never reaches the store
//   data and address bytes are kept
//   power-on also clears data, address, error
//
// hazards
//   the write gate is not cleared when a write ends
//   leaving it set invites stray writes
//   strobes cannot be cleared by software
//   a cut write must be redone by software
//   program store has no load path
//   program store contents start at zero
//   write timer is sized for the core clock
//   lower the timer count only in simulation
//
// timer
//   count loaded when the write starts
//   one clock per count
//   count of one ends the write
//   busy lasts exactly the count in clocks
//
// unlock tracking
//   none   no key byte seen
//   one    first key byte seen
//   two    both key bytes in order
//   a repeated first byte restarts the key
//   a wrong byte drops back to none
//
// sequencer states
//   idle     waits for a strobe
//   pmwait   extra clock of a program read
//   rdone    load of the read data
//   write    timed write in progress
//
// outputs
//   all three come from the state register
//   no output is combinational
module nvac_top
  import nvac_pkg::*;
#(
  parameter logic [31:0] WRITE_CYCLES = `NVAC_WRITE_CYC
)(
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  input  wire logic        POWER_ON,
  input  wire logic        BUS_WR,
  input  wire logic        BUS_RD,
  input  wire logic [7:0]  BUS_ADDR,
  input  wire logic [7:0]  BUS_WDATA,
  input  wire logic        FLAG_CLEAR,
  output var  logic [7:0]  BUS_RDATA,
  output var  logic        WRITE_COMPLETE_FLAG,
  output var  logic        WRITE_BUSY
);
  ////////////////////////////////////////////////////////////////
  // storage arrays
  logic [7:0]  ee_mem [0:`NVAC_EE_DEPTH-1];
  logic [13:0] pm_mem [0:`NVAC_PM_DEPTH-1];
  nvac_state_s s_q;
  nvac_state_s s_d;
  nvac_bus_s   bus;
  logic        ee_we;

  // register read mux
  function automatic logic [7:0] rd_mux(input nvac_state_s s, input logic [7:0] a);
    logic [7:0] v;
    v = `NVAC_RST_BYTE;
    case (a)
      `NVAC_OFF_DATA_LO: v = s.data_lo;
      `NVAC_OFF_DATA_HI: v = {2'h0, s.data_hi};
      `NVAC_OFF_ADDR_LO: v = s.addr_lo;
      `NVAC_OFF_ADDR_HI: v = {4'h0, s.addr_hi};
      `NVAC_OFF_CTRL:    v = {s.msel, 3'h0, s.write_error_flag, s.write_enable_gate, s.wr_bit, s.rd_bit};
      default:           v = `NVAC_RST_BYTE;
    endcase
    return v;
  endfunction

  assign bus = '{wr: BUS_WR, rd: BUS_RD, addr: BUS_ADDR, wdata: BUS_WDATA};

  ////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_d   = s_q;
    ee_we = 1'b0;
    s_d.rdata = rd_mux(s_q, bus.addr);
    // plain register writes
    if (bus.wr && s_q.state != NVAC_WRITE)
    begin
      case (bus.addr)
        `NVAC_OFF_DATA_LO: s_d.data_lo = bus.wdata;
        `NVAC_OFF_DATA_HI: s_d.data_hi = bus.wdata[5:0];
        `NVAC_OFF_ADDR_LO: s_d.addr_lo = bus.wdata;
        `NVAC_OFF_ADDR_HI: s_d.addr_hi = bus.wdata[3:0];
        default: ;
      endcase
    end
    // unlock sequence, any other write breaks it
    if (bus.wr && s_q.state != NVAC_WRITE)
    begin
      if (bus.addr == `NVAC_OFF_UNLOCK)
      begin
        if (bus.wdata == `NVAC_KEY1)
          s_d.lock = NVAC_LK_ONE;
        else if (bus.wdata == `NVAC_KEY2 && s_q.lock == NVAC_LK_ONE)
          s_d.lock = NVAC_LK_TWO;
        else
          s_d.lock = NVAC_LK_NONE;
      end
      else if (bus.addr != `NVAC_OFF_CTRL)
        s_d.lock = NVAC_LK_NONE;
    end
    // control register write
    if (bus.wr && bus.addr == `NVAC_OFF_CTRL)
    begin
      s_d.write_enable_gate = bus.wdata[`NVAC_BIT_WRITE_ENABLE_GATE];
      s_d.lock = NVAC_LK_NONE;
      if (s_q.state != NVAC_WRITE)
      begin
        s_d.msel  = bus.wdata[`NVAC_BIT_MSEL];
        s_d.write_error_flag = bus.wdata[`NVAC_BIT_WRITE_ERROR_FLAG];
        if (bus.wdata[`NVAC_BIT_RD] && s_q.state == NVAC_IDLE)
        begin
          s_d.rd_bit = 1'b1;
          s_d.state  = bus.wdata[`NVAC_BIT_MSEL] ? NVAC_PMWAIT : NVAC_RDONE;
        end
        else if (bus.wdata[`NVAC_BIT_WR] && !bus.wdata[`NVAC_BIT_MSEL] && s_q.write_enable_gate
                 && s_q.lock == NVAC_LK_TWO && s_q.state == NVAC_IDLE)
        begin
          s_d.wr_bit = 1'b1;
          s_d.state  = NVAC_WRITE;
          s_d.timer  = WRITE_CYCLES;
        end
      end
    end
    // operation sequencing
    case (s_q.state)
      NVAC_IDLE: ;
      NVAC_PMWAIT: s_d.state = NVAC_RDONE;
      NVAC_RDONE:
      begin
        if (s_q.msel)
          {s_d.data_hi, s_d.data_lo} = pm_mem[{s_q.addr_hi, s_q.addr_lo}];
        else
          s_d.data_lo = ee_mem[s_q.addr_lo];
        s_d.rd_bit = 1'b0;
        s_d.state  = NVAC_IDLE;
      end
      NVAC_WRITE:
      begin
        s_d.timer = s_q.timer - 32'h1;
        if (s_q.timer <= 32'h1)
        begin
          ee_we        = 1'b1;
          s_d.wr_bit   = 1'b0;
          s_d.done_flag = 1'b1;
          s_d.state    = NVAC_IDLE;
          s_d.lock     = NVAC_LK_NONE;
        end
      end
      default: s_d.state = NVAC_IDLE;
    endcase
    // software clear of completion flag loses to a new set
    if (FLAG_CLEAR && !ee_we)
      s_d.done_flag = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // state register and reset handling
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      s_q.state     <= NVAC_IDLE;
      s_q.lock      <= NVAC_LK_NONE;
      s_q.msel      <= 1'b0;
      s_q.wr_bit    <= 1'b0;
      s_q.rd_bit    <= 1'b0;
      s_q.write_enable_gate      <= 1'b0;
      s_q.done_flag <= 1'b0;
      s_q.timer     <= 32'h0;
      s_q.rdata     <= `NVAC_RST_BYTE;
      s_q.write_error_flag     <= (s_q.state == NVAC_WRITE);
      if (POWER_ON)
      begin
        s_q.data_lo <= `NVAC_RST_BYTE;
        s_q.data_hi <= 6'h0;
        s_q.addr_lo <= `NVAC_RST_BYTE;
        s_q.addr_hi <= 4'h0;
        s_q.write_error_flag   <= 1'b0;
      end
    end
    else
      s_q <= s_d;
  end

  // data store write, erase and program in one step
  always_ff @(posedge CLK_SYS)
  begin
    if (ee_we && !SRST)
      ee_mem[s_q.addr_lo] <= s_q.data_lo;
  end

  // program store is read-only here
  initial
  begin
    for (int i = 0; i < `NVAC_PM_DEPTH; i++)
      pm_mem[i] = 14'h0;
  end

  // outputs straight from state
  assign BUS_RDATA           = s_q.rdata;
  assign WRITE_COMPLETE_FLAG = s_q.done_flag;
  assign WRITE_BUSY          = s_q.wr_bit;
endmodule
`default_nettype wire

// *** nvac_props.sv ***
// port checker for the nv access block
`timescale 1ns/1ps
`default_nettype none
module nvac_props
  import nvac_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       SRST,
  input wire logic       POWER_ON,
  input wire logic       BUS_WR,
  input wire logic       BUS_RD,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  input wire logic       FLAG_CLEAR,
  input wire logic [7:0] BUS_RDATA,
  input wire logic       WRITE_COMPLETE_FLAG,
  input wire logic       WRITE_BUSY
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);
  // control write that asks for a data write
  logic ctl_wr;
  assign ctl_wr = BUS_WR && BUS_ADDR == 8'h9c && BUS_WDATA[1] && !BUS_WDATA[7];
  property p_busy_len; $rose(WRITE_BUSY) |-> WRITE_BUSY[*4] ##[1:12] !WRITE_BUSY; endproperty
  property p_busy_cause; $rose(WRITE_BUSY) |-> $past(ctl_wr); endproperty
  property p_flag_set; $fell(WRITE_BUSY) && !$past(SRST) |-> WRITE_COMPLETE_FLAG; endproperty
  property p_flag_cause; $rose(WRITE_COMPLETE_FLAG) |-> $fell(WRITE_BUSY); endproperty
  property p_flag_hold; WRITE_COMPLETE_FLAG && !FLAG_CLEAR |=> WRITE_COMPLETE_FLAG; endproperty
  property p_flag_clr; FLAG_CLEAR && !WRITE_BUSY |=> !WRITE_COMPLETE_FLAG; endproperty
  property p_unlock_zero; BUS_ADDR == 8'h9d |=> BUS_RDATA == 8'h00; endproperty
  property p_ctrl_zero; BUS_ADDR == 8'h9c |=> BUS_RDATA[6:4] == 3'h0; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  a_busy_cause: assert property (p_busy_cause) else $error("write without strobe");
  a_flag_set: assert property (p_flag_set) else $error("no done flag");
  a_flag_cause: assert property (p_flag_cause) else $error("stray done flag");
  a_flag_hold: assert property (p_flag_hold) else $error("done flag lost");
  a_flag_clr: assert property (p_flag_clr) else $error("done flag not cleared");
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock reads nonzero");
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("control 6..4 nonzero");
  c_write: cover property ($rose(WRITE_BUSY));
  c_done: cover property ($fell(WRITE_BUSY));
  c_clear: cover property (FLAG_CLEAR && WRITE_COMPLETE_FLAG);
endmodule
`default_nettype wire

// *** nvac_mem_model.sv ***
// reference image of the data store
`timescale 1ns/1ps
`default_nettype none
module nvac_mem_model;
  logic [7:0] mem [256];
  // byte write replaces the old value whole
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule
`default_nettype wire

// *** nvac_tb.sv ***
// self-checking bench for the nv access block
`timescale 1ns/1ps
`default_nettype none
module testbench import nvac_pkg::*;;
  logic       CLK_SYS = 0, SRST = 1, POWER_ON = 1, BUS_WR = 0, BUS_RD = 0, FLAG_CLEAR = 0;
  logic [7:0] BUS_ADDR = 0, BUS_WDATA = 0, BUS_RDATA, v;
  logic       WRITE_COMPLETE_FLAG, WRITE_BUSY;
  int         error_cnt = 0, comparisons = 0, cyc = 0;
  logic [31:0] tries [4] = '{32'h04000006, 32'h0055aa02, 32'h8455aa86, 32'h04aa5506};
  nvac_top #(.WRITE_CYCLES(32'h8)) nvac_top_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .POWER_ON(POWER_ON),
    .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .FLAG_CLEAR(FLAG_CLEAR),
    .BUS_RDATA(BUS_RDATA), .WRITE_COMPLETE_FLAG(WRITE_COMPLETE_FLAG), .WRITE_BUSY(WRITE_BUSY));
  nvac_mem_model nvac_mem_model_i ();
  // clock and hang guard
  initial
  begin
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // register write, one cycle pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    BUS_ADDR = a;
    BUS_WDATA = d;
    BUS_WR = 1'b1;
    @(posedge CLK_SYS);
    #1;
    BUS_WR = 1'b0;
    // idle clock so back-to-back calls never re-drive the strobe in one step
    @(posedge CLK_SYS);
    #1;
  endtask
  // register read, data one cycle after address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    BUS_ADDR = a;
    BUS_RD = 1'b1;
    @(posedge CLK_SYS);
    #1;
    d = BUS_RDATA;
    BUS_RD = 1'b0;
    // idle clock between reads
    @(posedge CLK_SYS);
    #1;
  endtask
  // nothing else is written between the two key bytes
  task automatic ulk;
    wr(8'h9d, 8'h55);
    wr(8'h9d, 8'haa);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  // main sequence
  initial
  begin
    tick(5);
    SRST = 0;
    POWER_ON = 0;
    for (int i = 0; i < 4; i++)
    begin
      rd(8'h9a + 8'(i), v);
      chk(v, 8'h00);
    end
    wr(8'h9c, 8'h74);
    rd(8'h9c, v);
    chk(v, 8'h04);
    wr(8'h9b, 8'h3c);
    wr(8'h9a, 8'hc3);
    ulk();
    wr(8'h9c, 8'h06);
    nvac_mem_model_i.put(8'h3c, 8'hc3);
    chk({7'h00, WRITE_BUSY}, 8'h01);
    wr(8'h9c, 8'h00);
    for (int i = 0; i < 40 && WRITE_BUSY !== 1'b0; i++)
      tick(1);
    chk({7'h00, WRITE_COMPLETE_FLAG}, 8'h01);
    FLAG_CLEAR = 1'b1;
    tick(1);
    FLAG_CLEAR = 1'b0;
    chk({7'h00, WRITE_COMPLETE_FLAG}, 8'h00);
    wr(8'h9a, 8'h00);
    wr(8'h9c, 8'h01);
    tick(2);
    rd(8'h9a, v);
    chk(v, nvac_mem_model_i.mem[8'h3c]);
    rd(8'h9c, v);
    chk(v, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h9c, tries[i][31:24]);
      wr(8'h9d, tries[i][23:16]);
      wr(8'h9d, tries[i][15:8]);
      wr(8'h9c, tries[i][7:0]);
      chk({7'h00, WRITE_BUSY}, 8'h00);
    end
    wr(8'h9a, 8'h77);
    wr(8'h97, 8'h3f);
    wr(8'h9c, 8'h81);
    tick(3);
    rd(8'h9a, v);
    chk(v, 8'h00);
    rd(8'h97, v);
    chk(v, 8'h00);
    wr(8'h9c, 8'h04);
    ulk();
    wr(8'h9c, 8'h06);
    SRST = 1'b1;
    tick(1);
    SRST = 1'b0;
    rd(8'h9c, v);
    chk(v, 8'h08);
    rd(8'h9b, v);
    chk(v, 8'h3c);
    complete_run();
  end
endmodule
bind nvac_top nvac_props nvac_props_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .POWER_ON(POWER_ON), .BUS_WR(BUS_WR),
  .BUS_RD(BUS_RD), .BUS_ADDR(BUS_ADDR), .BUS_WDATA(BUS_WDATA), .FLAG_CLEAR(FLAG_CLEAR), .BUS_RDATA(BUS_RDATA),
  .WRITE_COMPLETE_FLAG(WRITE_COMPLETE_FLAG), .WRITE_BUSY(WRITE_BUSY));
`default_nettype wire
